// file: verilog/emc_pkg.sv
package emc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int LSB_NS = 25600;
  localparam int UNIT_CYC = (LSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] UNIT_LAST = 11'(UNIT_CYC - 1);
  localparam int GAIN_STEP_NS = 204800;
  localparam int GAIN_STEP_UNITS = GAIN_STEP_NS / LSB_NS;
  localparam int TOL_SCALE = 10000;
  localparam int TOL_BP [4] = '{234, 540, 820, 1250};
  localparam int BW = 8;
  localparam int TW = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LOG = 8'h04;
  localparam logic [7:0] A_MODE = 8'h08;
  localparam logic [7:0] A_NOM = 8'h0C;
  localparam logic [7:0] A_TXP = 8'h10;
  localparam logic [7:0] A_RXP = 8'h14;
  localparam logic [7:0] A_USER = 8'h18;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_RES = 8'h2C;
  localparam int USER_WORDS = 4;
  localparam logic [31:0] USER_TOP_MASK = 32'h00FF_FFFF;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] pad3;
    logic [1:0] ringing_period_tolerance;
    logic [1:0] pad2;
    logic [5:0] drive_current_trim;
    logic [7:0] ringdown_watch_length;
    logic [1:0] pad1;
    logic [1:0] gain_ramp_filter_bw;
    logic [3:0] gain_ramp_begin;
  } emc_ctrl_s;

  typedef struct packed {
    logic [17:0] pad;
    logic [1:0] echo_log_interval;
    logic [11:0] echo_log_begin;
  } emc_log_s;

  typedef struct packed {
    logic [17:0] pad2;
    logic [5:0] flight_time_offset;
    logic [5:0] pad1;
    logic background_suppress_on;
    logic auto_carrier_tracking;
  } emc_mode_s;

  typedef struct packed {
    logic [24:0] pad;
    logic rx_nominal;
    logic used_ring;
    logic first_pend;
    logic log_on;
    logic ring_win;
    logic gain_on;
    logic measuring;
  } emc_stat_s;

  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_LOG = 32'h0000_1000;
  localparam logic [31:0] RST_MODE = 32'h0000_0000;
  localparam logic [15:0] RST_PERIOD = 16'h03E8;

endpackage

// file: verilog/emc_time_if.sv
`timescale 1ns/10ps
interface emc_time_if;
  logic tick;
  logic measuring;
  logic [15:0] elapsed;
  modport src (output tick, output measuring, output elapsed);
  modport snk (input tick, input measuring, input elapsed);
endinterface

// file: verilog/emc_timebase.sv
`timescale 1ns/10ps
module emc_timebase
  import emc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Measurement framing
  input wire logic start_in,
  input wire logic stop_in,
  // Time out
  emc_time_if.src tb
);

  // ----------------------------------------------------------------
  // Unit counter
  // ----------------------------------------------------------------
  logic [10:0] cyc;
  logic measuring;
  logic [15:0] elapsed;
  wire unit_end = measuring && (cyc == UNIT_LAST);
  wire sat = &elapsed;

  assign tb.tick = unit_end;
  assign tb.measuring = measuring;
  assign tb.elapsed = elapsed;

  // A new start restarts the time base even inside a running measurement.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc <= 11'h000;
      measuring <= 1'b0;
      elapsed <= 16'h0000;
    end else if (ce_in) begin
      if (start_in) begin
        cyc <= 11'h000;
        measuring <= 1'b1;
        elapsed <= 16'h0000;
      end else if (stop_in) begin
        measuring <= 1'b0;
      end else if (measuring) begin
        cyc <= unit_end ? 11'h000 : cyc + 11'h001;
        if (unit_end && !sat) begin
          elapsed <= elapsed + 16'h0001;
        end
      end
    end
  end

endmodule

// file: verilog/emc_config_bank.sv
`timescale 1ns/10ps
// Overview of operation
// - Gain ramp starts at code times 204.8 us
// - 120 user bits stored, never used internally
// - Echo logging starts at code times 25.6 us
// - Log period 25.6, 51.2, 102.4, 204.8 us
// - Tracking picks nominal or in-tolerance ringing period
// - Indirect measurement receives on nominal period
// - Suppress echo magnitude below noise background
// - Subtract offset from flight time before storing
module emc_config_bank
  import emc_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic CE_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Measurement events
  input wire logic MEAS_START_IN,
  input wire logic MEAS_STOP_IN,
  input wire logic INDIRECT_IN,
  input wire logic ECHO_DET_IN,
  input wire logic RING_VALID_IN,
  input wire logic [15:0] RING_PERIOD_IN,
  input wire logic [7:0] ECHO_MAG_IN,
  input wire logic [7:0] NOISE_LEVEL_IN,
  // Front end control
  output logic GAIN_RAMP_ON_OUT,
  output logic [1:0] GAIN_RAMP_BW_OUT,
  output logic RINGDOWN_WIN_OUT,
  output logic [5:0] DRIVE_TRIM_OUT,
  output logic LOG_SAMPLE_OUT,
  output logic [7:0] ECHO_MAG_OUT,
  output logic [15:0] TX_PERIOD_OUT,
  output logic [15:0] RX_PERIOD_OUT,
  output logic [15:0] TOF_OUT,
  output logic TOF_VALID_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*BW +: BW] = nw[i*BW +: BW];
      end
    end
    return r;
  endfunction

  function automatic logic within_tol(input logic [15:0] nom, input logic [15:0] meas, input logic [1:0] code);
    logic [31:0] diff;
    diff = (meas > nom) ? 32'(meas - nom) : 32'(nom - meas);
    return (diff * 32'(TOL_SCALE)) < (32'(nom) * 32'(TOL_BP[code]));
  endfunction

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    return (a >= b) ? a - b : 16'h0000;
  endfunction

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  emc_time_if tb ();

  emc_timebase emc_timebase_inst (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESET_N_IN),
    .ce_in(CE_IN),
    .start_in(MEAS_START_IN),
    .stop_in(MEAS_STOP_IN),
    .tb(tb.src)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  emc_ctrl_s ctrl;
  emc_log_s logr;
  emc_mode_s mode;
  emc_stat_s stat;
  logic [15:0] nom;
  logic [15:0] txp;
  logic [15:0] rxp;
  logic [31:0] user_mem [USER_WORDS];
  logic [15:0] tof;
  logic first_pend;
  logic ring_ok;
  logic [15:0] ring;
  logic used_ring;
  logic rx_nominal;

  wire [7:0] adr = {WB_ADR_IN[7:2], 2'b00};
  wire req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  wire wr = req && WB_WE_IN;
  wire wr_ctrl = wr && (adr == A_CTRL);
  wire wr_log = wr && (adr == A_LOG);
  wire wr_mode = wr && (adr == A_MODE);
  wire wr_nom = wr && (adr == A_NOM);
  wire wr_txp = wr && (adr == A_TXP);
  wire wr_rxp = wr && (adr == A_RXP);
  wire user_hit = (adr >= A_USER) && (adr < A_STAT);
  wire [1:0] user_idx = 2'((adr - A_USER) >> 2);
  wire wr_user = wr && user_hit;
  wire [31:0] user_mask = (user_idx == 2'(USER_WORDS - 1)) ? USER_TOP_MASK : 32'hFFFF_FFFF;
  wire [31:0] user_rd = user_mem[user_idx];

  wire [31:0] rd_mux =
    (adr == A_CTRL) ? ctrl :
    (adr == A_LOG) ? logr :
    (adr == A_MODE) ? mode :
    (adr == A_NOM) ? {16'h0000, nom} :
    (adr == A_TXP) ? {16'h0000, txp} :
    (adr == A_RXP) ? {16'h0000, rxp} :
    user_hit ? user_rd :
    (adr == A_STAT) ? stat :
    (adr == A_RES) ? {16'h0000, tof} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
      ctrl <= RST_CTRL;
      logr <= RST_LOG;
      mode <= RST_MODE;
      nom <= RST_PERIOD;
      txp <= RST_PERIOD;
      rxp <= RST_PERIOD;
    end else if (CE_IN) begin
      WB_ACK_OUT <= req;
      WB_DAT_OUT <= (req && !WB_WE_IN) ? rd_mux : 32'h0000_0000;
      if (wr_ctrl) ctrl <= merge(ctrl, WB_DAT_IN, WB_SEL_IN) & ~RST_CTRL;
      if (wr_log) logr <= merge(logr, WB_DAT_IN, WB_SEL_IN);
      if (wr_mode) mode <= merge(mode, WB_DAT_IN, WB_SEL_IN);
      if (wr_nom) nom <= 16'(merge({16'h0000, nom}, WB_DAT_IN, WB_SEL_IN));
      if (wr_txp) txp <= 16'(merge({16'h0000, txp}, WB_DAT_IN, WB_SEL_IN));
      if (wr_rxp) rxp <= 16'(merge({16'h0000, rxp}, WB_DAT_IN, WB_SEL_IN));
      // Pad bits are cleared in every enabled cycle so they always read as zero.
      ctrl.pad1 <= 2'b00;
      ctrl.pad2 <= 2'b00;
      ctrl.pad3 <= 6'h00;
      logr.pad <= 18'h00000;
      mode.pad1 <= 6'h00;
      mode.pad2 <= 18'h00000;
    end
  end

  // Marks that user word 0 holds a defined value, so its hold check never sees power-up junk.
  logic user0_set;

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      user0_set <= 1'b0;
    end else if (CE_IN && wr_user && (user_idx == 2'b00)) begin
      user0_set <= 1'b1;
    end
  end

  // The user words are plain storage with no reset; nothing but the bus reads them.
  always_ff @(posedge CLOCK_IN) begin
    if (CE_IN && wr_user) begin
      user_mem[user_idx] <= merge(user_mem[user_idx], WB_DAT_IN, WB_SEL_IN) & user_mask;
    end
  end

  // ----------------------------------------------------------------
  // Measurement timing
  // ----------------------------------------------------------------
  wire [15:0] gain_at = 16'(32'(ctrl.gain_ramp_begin) * GAIN_STEP_UNITS);
  wire [15:0] log_at = {4'h0, logr.echo_log_begin};
  wire [15:0] log_mask = 16'((32'h1 << logr.echo_log_interval) - 32'h1);
  wire [15:0] unit_next = tb.elapsed + 16'h0001;
  wire [15:0] log_rel = unit_next - log_at;
  wire next_gain = tb.measuring && (tb.elapsed >= gain_at);
  wire next_ring_win = tb.measuring && (tb.elapsed < 16'(ctrl.ringdown_watch_length));
  wire log_on = tb.measuring && (tb.elapsed >= log_at);
  // Samples fall on the unit boundary being entered, so for a nonzero start code the first one lands exactly at that code.
  wire next_log = tb.tick && !MEAS_START_IN && !MEAS_STOP_IN && (unit_next >= log_at) &&
                  ((log_rel & log_mask) == 16'h0000);
  wire next_suppress = mode.background_suppress_on && (ECHO_MAG_IN < NOISE_LEVEL_IN);
  wire [15:0] next_tof = sat_sub(tb.elapsed, 16'(mode.flight_time_offset));

  // ----------------------------------------------------------------
  // Carrier selection
  // ----------------------------------------------------------------
  wire track = mode.auto_carrier_tracking;
  wire take_ring = track && !first_pend && ring_ok && within_tol(nom, ring, ctrl.ringing_period_tolerance);
  wire [15:0] next_tx = !track ? txp : (take_ring ? ring : nom);
  wire [15:0] next_rx = INDIRECT_IN ? nom : (track ? next_tx : rxp);

  assign stat = '{pad: 25'h0, rx_nominal: rx_nominal, used_ring: used_ring, first_pend: first_pend,
                  log_on: log_on, ring_win: RINGDOWN_WIN_OUT, gain_on: GAIN_RAMP_ON_OUT,
                  measuring: tb.measuring};

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      GAIN_RAMP_ON_OUT <= 1'b0;
      GAIN_RAMP_BW_OUT <= 2'b00;
      RINGDOWN_WIN_OUT <= 1'b0;
      DRIVE_TRIM_OUT <= 6'h00;
      LOG_SAMPLE_OUT <= 1'b0;
      ECHO_MAG_OUT <= 8'h00;
      TX_PERIOD_OUT <= RST_PERIOD;
      RX_PERIOD_OUT <= RST_PERIOD;
      TOF_OUT <= 16'h0000;
      TOF_VALID_OUT <= 1'b0;
      tof <= 16'h0000;
      first_pend <= 1'b1;
      ring_ok <= 1'b0;
      ring <= 16'h0000;
      used_ring <= 1'b0;
      rx_nominal <= 1'b0;
    end else if (CE_IN) begin
      GAIN_RAMP_ON_OUT <= next_gain;
      GAIN_RAMP_BW_OUT <= ctrl.gain_ramp_filter_bw;
      RINGDOWN_WIN_OUT <= next_ring_win;
      DRIVE_TRIM_OUT <= ctrl.drive_current_trim;
      LOG_SAMPLE_OUT <= next_log;
      ECHO_MAG_OUT <= next_suppress ? 8'h00 : ECHO_MAG_IN;
      TOF_VALID_OUT <= ECHO_DET_IN && tb.measuring;
      if (ECHO_DET_IN && tb.measuring) begin
        TOF_OUT <= next_tof;
        tof <= next_tof;
      end
      if (RING_VALID_IN) begin
        ring <= RING_PERIOD_IN;
        ring_ok <= 1'b1;
      end
      if (MEAS_START_IN) begin
        TX_PERIOD_OUT <= next_tx;
        RX_PERIOD_OUT <= next_rx;
        used_ring <= take_ring;
        rx_nominal <= INDIRECT_IN;
      end
      // A new nominal period wins over the clear made by a start in the same cycle.
      if (wr_nom) begin
        first_pend <= 1'b1;
        // A ring sample arriving with the write is newer than the write, so it is kept.
        ring_ok <= RING_VALID_IN;
      end else if (MEAS_START_IN && track) begin
        first_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  sequence s_first_start;
    CE_IN && MEAS_START_IN && track && first_pend && !INDIRECT_IN && !wr_nom;
  endsequence

  sequence s_echo;
    CE_IN && ECHO_DET_IN && tb.measuring;
  endsequence

  property p_gain_start;
    CE_IN && tb.measuring && !MEAS_START_IN && !MEAS_STOP_IN ##1 CE_IN |->
      GAIN_RAMP_ON_OUT == ($past(tb.elapsed) >= 16'($past(ctrl.gain_ramp_begin)) * 16'(GAIN_STEP_UNITS));
  endproperty
  a_gain_start: assert property (p_gain_start) else $error("gain ramp start time wrong");

  property p_user_hold;
    CE_IN && !wr_user && user0_set |=> user_mem[0] == $past(user_mem[0]);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user word changed without write");

  property p_ring_win;
    RINGDOWN_WIN_OUT |-> $past(tb.elapsed) < {8'h00, $past(ctrl.ringdown_watch_length)};
  endproperty
  a_ring_win: assert property (p_ring_win) else $error("ringdown window too long");

  property p_log_begin;
    LOG_SAMPLE_OUT |-> tb.elapsed >= {4'h0, $past(logr.echo_log_begin)};
  endproperty
  a_log_begin: assert property (p_log_begin) else $error("logging before start time");

  property p_log_step;
    LOG_SAMPLE_OUT && logr.echo_log_interval == 2'h3 && $stable(logr) |->
      ((tb.elapsed - log_at) & 16'h0007) == 16'h0000;
  endproperty
  a_log_step: assert property (p_log_step) else $error("log sample off its step");

  property p_first_nominal;
    s_first_start |=> TX_PERIOD_OUT == $past(nom) && RX_PERIOD_OUT == $past(nom) && !first_pend;
  endproperty
  a_first_nominal: assert property (p_first_nominal) else $error("first tracked period not nominal");

  property p_indirect;
    CE_IN && MEAS_START_IN && INDIRECT_IN |=> RX_PERIOD_OUT == $past(nom) && rx_nominal;
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect receive not nominal");

  property p_suppress;
    CE_IN && mode.background_suppress_on && ECHO_MAG_IN < NOISE_LEVEL_IN |=> ECHO_MAG_OUT == 8'h00;
  endproperty
  a_suppress: assert property (p_suppress) else $error("noise not suppressed");

  property p_tof;
    s_echo |=> TOF_VALID_OUT && TOF_OUT == sat_sub($past(tb.elapsed), {10'h000, $past(mode.flight_time_offset)})
      ##1 !TOF_VALID_OUT || $past(CE_IN && ECHO_DET_IN);
  endproperty
  a_tof: assert property (p_tof) else $error("flight time offset not applied");

endmodule

// file: dv/emc_ecu_model.sv
`timescale 1ns/10ps
module emc_ecu_model
  import emc_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Wishbone master
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [7:0] adr_out,
  output logic [3:0] sel_out,
  output logic [31:0] dat_out,
  input wire logic [31:0] dat_in,
  input wire logic ack_in
);
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 8'h00;
    sel_out = 4'h0;
    dat_out = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Single classic cycles
  // ----------------------------------------------------------------
  // The master keeps the whole request up until ack is sampled, so a slow slave is safe.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    sel_out <= 4'hF;
    dat_out <= d;
    @(posedge clk_in);
    while (ack_in !== 1'b1) @(posedge clk_in);
    q = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out <= 1'b0;
  endtask

  // The master alone picks the flight time offset to suit its filter setting.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
endmodule

// file: dv/emc_config_bank_test.sv
`timescale 1ns/10ps
module emc_config_bank_test
  import emc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic indir = 1'b0;
  logic echo = 1'b0;
  logic rv = 1'b0;
  logic [15:0] ring = 16'h0000;
  logic [7:0] mag = 8'h00;
  logic [7:0] noise = 8'h00;
  logic ce = 1'b1;
  logic cyc, stb, we, ack, gain, rwin, logs, tofv;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r, x;
  logic [1:0] bw;
  logic [5:0] trim;
  logic [7:0] mago;
  logic [15:0] txp, rxp, tof;
  int miscompares = 0;
  int total_checks = 0;
  int nlog = 0;
  int in_tol [4] = '{23, 53, 81, 124};
  int logn [4] = '{8, 4, 2, 1};
  int e;

  initial forever #10 clk = ~clk;

  emc_ecu_model emc_ecu_model_inst (.clk_in(clk), .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr),
    .sel_out(sel), .dat_out(wdat), .dat_in(rdat), .ack_in(ack));

  emc_config_bank emc_config_bank_inst (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .MEAS_START_IN(start), .MEAS_STOP_IN(stop), .INDIRECT_IN(indir), .ECHO_DET_IN(echo),
    .RING_VALID_IN(rv), .RING_PERIOD_IN(ring), .ECHO_MAG_IN(mag), .NOISE_LEVEL_IN(noise),
    .GAIN_RAMP_ON_OUT(gain), .GAIN_RAMP_BW_OUT(bw), .RINGDOWN_WIN_OUT(rwin), .DRIVE_TRIM_OUT(trim),
    .LOG_SAMPLE_OUT(logs), .ECHO_MAG_OUT(mago), .TX_PERIOD_OUT(txp), .RX_PERIOD_OUT(rxp), .TOF_OUT(tof),
    .TOF_VALID_OUT(tofv));

  always @(posedge clk) if (logs === 1'b1) nlog++;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    emc_ecu_model_inst.rd(a, r);
    chk(nm, x, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    emc_ecu_model_inst.wr(a, d);
  endtask

  // Pulses last one cycle; the bench's own edge count fixes their width.
  task automatic pulse_start(input logic ind);
    @(posedge clk);
    start <= 1'b1;
    indir <= ind;
    @(posedge clk);
    start <= 1'b0;
    nlog = 0;
    repeat (2) @(posedge clk);
  endtask

  task automatic ringp(input int p);
    @(posedge clk);
    ring <= 16'(p);
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(A_CTRL, 32'h0000_0000, "ctrl");
    rdc(A_LOG, 32'h0000_1000, "log");
    rdc(A_MODE, 32'h0000_0000, "mode");
    rdc(8'h30, 32'h0000_0000, "unmapped");
    wr(A_RES, 32'hFFFF_FFFF);
    rdc(A_RES, 32'h0000_0000, "res");
    for (int i = 0; i < 4; i++) wr(A_USER + 8'(4 * i), 32'hA5C3_0F00 + i);
    for (int i = 0; i < 4; i++) begin
      x = (i == 3) ? (32'hA5C3_0F03 & USER_TOP_MASK) : 32'hA5C3_0F00 + 32'(i);
      rdc(A_USER + 8'(4 * i), x, "user");
    end
    wr(A_MODE, 32'h0000_0002);
    @(posedge clk);
    mag <= 8'h05;
    noise <= 8'h09;
    repeat (3) @(posedge clk);
    chk("mag low", 32'h0, mago);
    mag <= 8'h0C;
    repeat (3) @(posedge clk);
    chk("mag high", 32'h0C, mago);
    wr(A_MODE, 32'h0000_0000);
    mag <= 8'h05;
    repeat (3) @(posedge clk);
    chk("mag off", 32'h05, mago);
    wr(A_NOM, 32'h0000_03E8);
    wr(A_MODE, 32'h0000_0001);
    ringp(1010);
    pulse_start(1'b0);
    chk("tx first", 32'h3E8, txp);
    for (int t = 0; t < 4; t++) begin
      wr(A_CTRL, 32'(t) << 24);
      ringp(1000 + in_tol[t]);
      pulse_start(1'b0);
      chk("tx ring", 32'(1000 + in_tol[t]), txp);
      chk("rx ring", 32'(1000 + in_tol[t]), rxp);
      ringp(1001 + in_tol[t]);
      pulse_start(1'b0);
      chk("tx nom", 32'h3E8, txp);
    end
    ringp(1010);
    pulse_start(1'b1);
    chk("tx ind", 32'h0000_03F2, txp);
    chk("rx ind", 32'h3E8, rxp);
    wr(A_MODE, 32'h0000_0000);
    wr(A_TXP, 32'h0000_0500);
    wr(A_RXP, 32'h0000_0600);
    pulse_start(1'b0);
    chk("tx fixed", 32'h500, txp);
    chk("rx fixed", 32'h600, rxp);
    wr(A_CTRL, 32'h0005_0321);
    @(posedge clk);
    chk("trim", 32'h5, trim);
    chk("bw", 32'h2, bw);
    for (int i = 0; i < 4; i++) begin
      wr(A_LOG, (32'(i) << 12) | 32'h1);
      wr(A_MODE, 32'(3 * i) << 8);
      pulse_start(1'b0);
      repeat (UNIT_CYC * 5 / 2) @(posedge clk);
      chk("ring on", 32'h1, rwin);
      chk("gain early", 32'h0, gain);
      repeat (UNIT_CYC) @(posedge clk);
      chk("ring off", 32'h0, rwin);
      repeat (UNIT_CYC * 5) @(posedge clk);
      chk("gain on", 32'h1, gain);
      chk("log count", 32'(logn[i]), 32'(nlog));
      echo <= 1'b1;
      @(posedge clk);
      echo <= 1'b0;
      #1;
      e = (3 * i > 8) ? 0 : 8 - 3 * i;
      chk("tof valid", 32'h1, tofv);
      chk("tof", 32'(e), tof);
      rdc(A_RES, 32'(e), "res tof");
    end
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    echo <= 1'b1;
    @(posedge clk);
    echo <= 1'b0;
    #1;
    chk("echo idle", 32'h0, tofv);
    @(posedge clk);
    mag <= 8'h33;
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ce hold", 32'h05, mago);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ce run", 32'h33, mago);
    complete_run();
  end
endmodule
